// [rtl/dtgb_bank.sv]
// Sixteen-bin recursive tone detector bank, sample strobed
`default_nettype none
module dtgb_bank #(
  parameter int SAMPLE_CYC = dtgb_pkg::SAMPLE_CYC
) (
  // Clock and reset
  input  wire logic                           ref_clk,
  input  wire logic                           nrst,
  // Sample input, one strobe per 8 kHz period
  input  wire logic                           smp_stb,
  input  wire logic [dtgb_pkg::SMP_W-1:0]     smp_data,
  // Result stream
  output var  logic                           res_valid,
  input  wire logic                           res_ready,
  output var  dtgb_pkg::dtgb_result_s         res_data,
  output var  logic                           res_done,
  // Status
  output var  logic [dtgb_pkg::IDX_W-1:0]     smp_index,
  output var  logic                           drop_stb
);
  // ****************************************************************
  // Arithmetic helpers
  // ****************************************************************
  localparam int QW = dtgb_pkg::Q_W;
  localparam int PW = dtgb_pkg::P_W;
  // Coefficient times state in fixed point, rounded toward minus infinity
  function automatic logic signed [QW-1:0] cmul(input logic signed [15:0] c,
                                                input logic signed [QW-1:0] q);
    logic signed [QW+15:0] p;
    p = c * q;
    return p[QW-1+dtgb_pkg::C_FRAC:dtgb_pkg::C_FRAC];
  endfunction
  // Squared-magnitude form from last two states
  function automatic logic [PW-1:0] pwr(input logic signed [15:0] c,
                                        input logic signed [QW-1:0] a,
                                        input logic signed [QW-1:0] b);
    logic signed [PW-1:0] aa;
    logic signed [PW-1:0] bb;
    logic signed [PW-1:0] ab;
    aa = PW'(a) * PW'(a);
    bb = PW'(b) * PW'(b);
    ab = PW'(cmul(c, a)) * PW'(b);
    return aa + bb - ab;
  endfunction
  // ****************************************************************
  // Sample strobe input sync and edge detect
  // ****************************************************************
  logic       stb_m;                          // First stage, read only by stb_s
  logic       stb_s;                          // Second stage
  logic       stb_d;                          // Previous sync level
  logic [dtgb_pkg::SMP_W-1:0] dat_m;          // Sample sync stage 1
  logic [dtgb_pkg::SMP_W-1:0] dat_s;          // Sample sync stage 2
  // Two flops on the asynchronous strobe and data
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      stb_m <= 1'b0;
      stb_s <= 1'b0;
      stb_d <= 1'b0;
      dat_m <= '0;
      dat_s <= '0;
    end else begin
      stb_m <= smp_stb;
      stb_s <= stb_m;
      stb_d <= stb_s;
      dat_m <= smp_data;
      dat_s <= dat_m;
    end
  end
  wire new_smp = stb_s & ~stb_d;  // One pulse per sample
  // ****************************************************************
  // State storage and control
  // ****************************************************************
  dtgb_pkg::dtgb_qpair_s q [dtgb_pkg::NUM_DET];  // Feedback states
  dtgb_pkg::dtgb_state_e st;                     // Sequencer state
  logic [dtgb_pkg::DET_W-1:0] det;               // Detector being worked
  logic signed [QW-1:0]       x;                 // Scaled current sample
  // Scale down by eight bits, sign kept (see RL18)
  wire signed [QW-1:0] x_scaled = QW'($signed(dat_s[dtgb_pkg::SMP_W-1:dtgb_pkg::IN_SHIFT]));
  // Harmonics stop after 201 samples, fundamentals after 205 (see RL1) (see RL2)
  wire in_harm_win = (smp_index < dtgb_pkg::IDX_W'(dtgb_pkg::LEN_HARM));   // see RL3
  wire in_fund_win = (smp_index < dtgb_pkg::IDX_W'(dtgb_pkg::LEN_FUND));   // see RL4
  // Last update sweep covers only the fundamentals past index 200 (see RL5)
  wire [dtgb_pkg::DET_W-1:0] last_det = in_harm_win ? 4'hF : 4'h7;
  wire signed [15:0] c_sel = $signed(dtgb_pkg::COEF[det]);  // see RL12 see RL13 see RL14 see RL15
  wire signed [QW-1:0] q_new = cmul(c_sel, $signed(q[det].q1))
                               - $signed(q[det].q2) + x;  // see RL16
  logic                   in_ready_w;  // Buffer has room
  dtgb_pkg::dtgb_result_s res_in;      // Result entering the buffer
  wire res_push  = (st == dtgb_pkg::DTGB_EVAL);
  wire res_stall = res_push && !in_ready_w;
  // Whole struct driven at once, so it keeps a single driver
  assign res_in = {det, pwr(c_sel, $signed(q[det].q1), $signed(q[det].q2))}; // see RL7 see RL17
  // Sequencer: one update sweep per sample, then one evaluation slot
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      st        <= dtgb_pkg::DTGB_IDLE;
      det       <= '0;
      x         <= '0;
      smp_index <= '0;
      drop_stb  <= 1'b0;
      res_done  <= 1'b0;
    end else begin
      drop_stb <= 1'b0;
      res_done <= 1'b0;
      unique case (st)
        dtgb_pkg::DTGB_IDLE: begin
          if (new_smp) begin
            // Frame begins on whatever sample comes next (see RL10)
            if (in_fund_win) begin
              x   <= x_scaled;
              det <= '0;
              st  <= dtgb_pkg::DTGB_UPD;
            end else begin
              // Slot 205 discards its sample and evaluates (see RL6) (see RL8)
              det      <= '0;
              drop_stb <= 1'b1;
              st       <= dtgb_pkg::DTGB_EVAL;
            end
          end
        end
        dtgb_pkg::DTGB_UPD: begin
          if (new_smp) drop_stb <= 1'b1;
          if (det == last_det) begin
            smp_index <= smp_index + 8'h01;
            st        <= dtgb_pkg::DTGB_IDLE;
          end else begin
            det <= det + 4'h1;
          end
        end
        dtgb_pkg::DTGB_EVAL: begin
          // Samples arriving while results drain are dropped (see RL9)
          if (new_smp) drop_stb <= 1'b1;
          if (!res_stall) begin
            if (det == 4'hF) begin
              smp_index <= '0;                 // see RL19
              res_done  <= 1'b1;               // see RL20
              st        <= dtgb_pkg::DTGB_IDLE;
            end else begin
              det <= det + 4'h1;
            end
          end
        end
        default: st <= dtgb_pkg::DTGB_IDLE;
      endcase
    end
  end
  // Feedback state update, cleared after each evaluated frame
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      for (int i = 0; i < dtgb_pkg::NUM_DET; i++) q[i] <= '0;
    end else if (st == dtgb_pkg::DTGB_EVAL && !res_stall && det == 4'hF) begin
      for (int i = 0; i < dtgb_pkg::NUM_DET; i++) q[i] <= '0;  // see RL19
    end else if (st == dtgb_pkg::DTGB_UPD) begin
      q[det].q1 <= q_new;            // see RL16
      q[det].q2 <= q[det].q1;
    end
  end
  // ****************************************************************
  // Result buffer; a stalled receiver holds the sweep
  // ****************************************************************
  logic                    buf_valid;
  dtgb_pkg::dtgb_result_s  buf_data;
  // Output stage takes a word when empty or when its word leaves
  wire                     out_take = !res_valid || res_ready;
  dtgb_skid #(
    .W ($bits(dtgb_pkg::dtgb_result_s))
  ) u_skid (
    .ref_clk   (ref_clk),
    .nrst      (nrst),
    .in_valid  (res_push),
    .in_ready  (in_ready_w),
    .in_data   (res_in),
    .out_valid (buf_valid),
    .out_ready (out_take),
    .out_data  (buf_data)
  );
  // Output register stage so outputs come from flops
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      res_valid <= 1'b0;
      res_data  <= '0;
    end else if (out_take) begin
      res_valid <= buf_valid;
      res_data  <= buf_data;
    end
  end
endmodule
`default_nettype wire

// [rtl/dtgb_pkg.sv]
// Package of constants and types for the dual-tone detector bank
// Operation
// RL1: Fundamental detectors accumulate exactly 205 samples
// RL2: Harmonic detectors accumulate exactly 201 samples
// RL3: Indices 0..200 update all sixteen detectors
// RL4: Indices 201..204 update only fundamental detectors
// RL5: Harmonics hold state during indices 201..204
// RL6: Index 205 evaluates outputs, discards sample
// RL7: Output is squared magnitude, no phase
// RL8: Frame spans frame length plus one
// RL9: Results go downstream; later samples may drop
// RL10: Frame starts on next sample, no alignment
// RL11: Source delivers one sample at 8 kHz
// RL12: Low fundamental coefficients from table
// RL13: High fundamental coefficients from table
// RL14: Low harmonic coefficients from table
// RL15: High harmonic coefficients from table
// RL16: New state is coef*q1 - q2 + x
// RL17: Power is a^2 + b^2 - a*b*coef
// RL18: Input scaled down by eight bits
// RL19: Clear states and counter before next frame
// RL20: Results presented with one-cycle valid strobe; res_valid holds each result until res_ready instead
`default_nettype none
package dtgb_pkg;
  // ****************************************************************
  // Sizes
  // ****************************************************************
  localparam int NUM_DET   = 16;        // Detectors in the bank
  localparam int NUM_FUND  = 8;         // Fundamental detectors first
  localparam int LEN_FUND  = 205;       // Fundamental frame length
  localparam int LEN_HARM  = 201;       // Harmonic frame length
  localparam int SMP_W     = 16;        // Linear sample width
  localparam int IN_SHIFT  = 8;         // Input scaling shift
  localparam int Q_W       = 24;        // Feedback state width
  localparam int C_FRAC    = 14;        // Coefficient fraction bits (Q2.14)
  localparam int C_W       = 16;        // Coefficient width
  localparam int P_W       = 48;        // Power result width
  localparam int IDX_W     = 8;         // Sample index width
  localparam int DET_W     = 4;         // Detector select width
  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int REF_CLK_HZ  = 40000000; // Core clock rate
  localparam int SAMPLE_HZ   = 8000;     // Sample rate of the source
  localparam int SAMPLE_CYC  = REF_CLK_HZ / SAMPLE_HZ; // Cycles per sample
  // ****************************************************************
  // Coefficients, 2cos(2 pi k/N) rounded to Q2.14
  // ****************************************************************
  localparam logic [C_W-1:0] COEF [NUM_DET] = '{
    16'h6D02, 16'h68B2, 16'h63FD, 16'h5EE7,  // 1.703275 1.635859 1.562297 1.482867
    16'h4A71, 16'h4091, 16'h3291, 16'h23CE,  // 1.163138 1.008835 0.790074 0.559454
    16'h3ABC, 16'h2C17, 16'h1CC3, 16'h0CFB,  // 0.917716 0.688934 0.449394 0.202838
    16'hD5CB, 16'hC000, 16'hA977, 16'h94D0}; // -0.659504 -1.0 -1.352140 -1.674783
  // ****************************************************************
  // Types
  // ****************************************************************
  typedef enum logic [1:0] {
    DTGB_IDLE = 2'b00,   // Waiting for a sample
    DTGB_UPD  = 2'b01,   // Sweeping feedback updates
    DTGB_EVAL = 2'b11    // Sweeping power evaluation
  } dtgb_state_e;
  typedef struct packed {
    logic [Q_W-1:0] q1;  // Latest state
    logic [Q_W-1:0] q2;  // State before that
  } dtgb_qpair_s;
  typedef struct packed {
    logic [DET_W-1:0] det;  // Which detector
    logic [P_W-1:0]   pwr;  // Squared magnitude
  } dtgb_result_s;
endpackage
`default_nettype wire

// [rtl/dtgb_skid.sv]
// Two-entry valid/ready buffer for detector results
`default_nettype none
module dtgb_skid #(
  parameter int W = 52
) (
  // Clock and reset
  input  wire logic         ref_clk,
  input  wire logic         nrst,
  // Fill side
  input  wire logic         in_valid,
  output var  logic         in_ready,
  input  wire logic [W-1:0] in_data,
  // Drain side
  output var  logic         out_valid,
  input  wire logic         out_ready,
  output var  logic [W-1:0] out_data
);
  // ****************************************************************
  // Storage
  // ****************************************************************
  logic [W-1:0] mem [2];   // Two entries
  logic         wp;        // Write slot
  logic         rp;        // Read slot
  logic [1:0]   cnt;       // Entries held
  wire          push = in_valid && (cnt != 2'h2);
  wire          pop  = out_valid && out_ready;
  // Pointers and count; full refuses, so nothing is overwritten
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      wp  <= 1'b0;
      rp  <= 1'b0;
      cnt <= 2'h0;
    end else begin
      if (push) wp <= ~wp;
      if (pop) rp <= ~rp;
      cnt <= cnt + {1'b0, push} - {1'b0, pop};
    end
  end
  // Entry write
  always_ff @(posedge ref_clk) begin
    if (push) mem[wp] <= in_data;
  end
  assign in_ready  = (cnt != 2'h2);
  assign out_valid = (cnt != 2'h0);
  assign out_data  = mem[rp];
endmodule
`default_nettype wire

// [tb/dtgb_bank_chk.sv]
// Port checker for the tone detector bank
`default_nettype none
module dtgb_bank_chk #(
  parameter int SAMPLE_CYC = 100
) (
  // Clock and reset
  input wire logic                       ref_clk,
  input wire logic                       nrst,
  // Sample side
  input wire logic                       smp_stb,
  input wire logic [dtgb_pkg::SMP_W-1:0] smp_data,
  // Result side
  input wire logic                       res_valid,
  input wire logic                       res_ready,
  input wire dtgb_pkg::dtgb_result_s     res_data,
  input wire logic                       res_done,
  input wire logic [dtgb_pkg::IDX_W-1:0] smp_index,
  input wire logic                       drop_stb
);
  timeunit 1ns;
  timeprecision 1ps;
  // ****************************************
  // Helpers
  // ****************************************
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!nrst);
  logic [3:0] exp_det;   // Detector due next on the stream
  logic [7:0] prev_idx;  // Index one cycle back
  wire logic  idx_moved; // Index changed this cycle
  assign idx_moved = smp_index != prev_idx;
  // Track handshakes and the last index
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      exp_det  <= 4'h0;
      prev_idx <= 8'h00;
    end else begin
      prev_idx <= smp_index;
      if (res_valid && res_ready) begin
        exp_det <= exp_det + 4'h1;
      end
    end
  end
  sequence s_new_smp;
    $rose(smp_stb);
  endsequence
  sequence s_handled;
    drop_stb || idx_moved || res_valid;
  endsequence
  // ****************************************
  // Assertions
  // ****************************************
  smp_taken_a: assert property (s_new_smp |-> ##[1:200] s_handled)
    else $error("sample strobe left unhandled");
  idx_range_a: assert property (smp_index <= 8'hCD)
    else $error("sample index beyond frame");
  idx_step_a: assert property (idx_moved |->
    (smp_index == prev_idx + 8'h01) || (smp_index == 8'h00))
    else $error("sample index skipped");
  done_pulse_a: assert property (res_done |=> !res_done)
    else $error("done strobe too long");
  drop_pulse_a: assert property (drop_stb |=> !drop_stb)
    else $error("drop strobe too long");
  res_hold_a: assert property (res_valid && !res_ready |=>
    res_valid && $stable(res_data))
    else $error("result changed while stalled");
  det_order_a: assert property (res_valid |-> res_data.det == exp_det)
    else $error("result out of detector order");
  clear_idx_a: assert property (res_done |-> ##[0:4] (smp_index == 8'h00))
    else $error("index not cleared after frame");
endmodule
bind dtgb_bank dtgb_bank_chk #(.SAMPLE_CYC(SAMPLE_CYC)) u_chk (
  .ref_clk(ref_clk), .nrst(nrst), .smp_stb(smp_stb), .smp_data(smp_data),
  .res_valid(res_valid), .res_ready(res_ready), .res_data(res_data), .res_done(res_done),
  .smp_index(smp_index), .drop_stb(drop_stb));
`default_nettype wire

// [tb/dtgb_bank_tb_top.sv]
// Self-checking bench for the tone detector bank
`default_nettype none
module dtgb_bank_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int PER = 100; // Shortened sample period
  logic                   ref_clk = 1'b0;
  logic                   nrst = 1'b0;
  logic                   res_ready = 1'b1;
  logic [3:0][15:0]       vals = '0;
  logic                   smp_stb;
  logic [15:0]            smp_data;
  logic                   res_valid;
  logic                   res_done;
  logic                   drop_stb;
  logic [7:0]             smp_index;
  dtgb_pkg::dtgb_result_s res_data;
  int                     fails = 0;
  int                     num_checks = 0;
  int                     dones = 0;
  int                     drops = 0; // Discarded samples seen
  always #12.5 ref_clk = ~ref_clk;
  // Count frame completions and dropped samples
  always @(posedge ref_clk) begin
    if (res_done === 1'b1) begin
      dones++;
    end
    if (drop_stb === 1'b1) begin
      drops++;
    end
  end
  dtgb_src #(.PERIOD(PER)) u_src (.ref_clk(ref_clk), .nrst(nrst), .vals(vals),
    .smp_stb(smp_stb), .smp_data(smp_data));
  dtgb_bank #(.SAMPLE_CYC(PER)) u_dut (.ref_clk(ref_clk), .nrst(nrst), .smp_stb(smp_stb),
    .smp_data(smp_data), .res_valid(res_valid), .res_ready(res_ready), .res_data(res_data),
    .res_done(res_done), .smp_index(smp_index), .drop_stb(drop_stb));
  task automatic check(input logic [47:0] seen, input logic [47:0] exp, input string what);
    num_checks++;
    if (seen !== exp) begin
      fails++;
      $display("unexpected at %0t: %s seen %0h want %0h", $time, what, seen, exp);
    end
  endtask
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  // One frame: load values, drain sixteen results, judge zero or not
  task automatic get_frame(input logic [3:0][15:0] v, input int stall, input logic [15:0] nz);
    int d0;
    int p0;
    int i;
    int w;
    d0 = dones;
    p0 = drops;
    vals = v;
    for (i = 0; i < 16; i++) begin
      for (w = 0; w < 30000 && res_valid !== 1'b1; w++) @(negedge ref_clk);
      if (i == 0 && stall > 0) begin
        res_ready = 1'b0; // Receiver stalls, buffer must hold
        repeat (stall) @(negedge ref_clk);
        res_ready = 1'b1;
      end
      check({44'h0, res_data.det}, {44'h0, 4'(i)}, "order");
      check({47'h0, res_data.pwr !== '0}, {47'h0, nz[i]}, "power");
      @(negedge ref_clk);
    end
    repeat (8) @(negedge ref_clk);
    check(48'(dones - d0), 48'h1, "done");
    check(48'(drops - p0), 48'h1, "drops");
    check({40'h0, smp_index}, 48'h0, "index");
  endtask
  task automatic test_all_update();
    get_frame({16'h0000, 16'h0000, 16'hF000, 16'h1000}, 0, 16'hFFFF);
    $display("test all update done");
  endtask
  task automatic test_scale_discard();
    get_frame({16'h7F00, 16'h00FF, 16'h0080, 16'h00FF}, 0, 16'h0000);
    $display("test scale discard done");
  endtask
  task automatic test_harm_hold();
    get_frame({16'h0000, 16'h4000, 16'h0000, 16'h0000}, 20, 16'h00FF);
    $display("test harm hold done");
  endtask
  initial begin
    repeat (12) @(negedge ref_clk);
    nrst = 1'b1;
    test_all_update();
    test_scale_discard();
    test_harm_hold();
    tally_and_finish();
  end
  // Watchdog: three frames of 206 periods plus margin
  initial begin
    repeat (3 * 206 * PER + 20000) @(posedge ref_clk);
    fails++;
    $display("unexpected at %0t: watchdog expired", $time);
    tally_and_finish();
  end
endmodule
`default_nettype wire

// [tb/dtgb_src.sv]
// Codec model delivering one sample strobe per sample period
`default_nettype none
module dtgb_src #(
  parameter int PERIOD = 100
) (
  // Clock and reset
  input  wire logic             ref_clk,
  input  wire logic             nrst,
  // Values: even, odd, tail 201..204, slot 205
  input  wire logic [3:0][15:0] vals,
  // Sample port
  output var  logic             smp_stb,
  output var  logic [15:0]      smp_data
);
  timeunit 1ns;
  timeprecision 1ps;
  int cyc; // Cycles into the period
  int k;   // Sample number within the frame
  // Fixed rate strobe, data set one cycle ahead so it is stable
  always @(negedge ref_clk) begin
    if (!nrst) begin
      cyc = 0;
      k = 0;
      smp_stb <= 1'b0;
      smp_data <= 16'h5A5A;
    end else begin
      cyc = (cyc == PERIOD - 1) ? 0 : cyc + 1;
      if (cyc == PERIOD - 2) begin
        smp_data <= (k == 205) ? vals[3] : (k > 200) ? vals[2] : vals[k % 2];
      end else if (cyc == PERIOD - 1) begin
        smp_stb <= 1'b1;
        k = (k == 205) ? 0 : k + 1;
      end else if (cyc == PERIOD / 2) begin
        smp_stb <= 1'b0;
        smp_data <= ~smp_data; // Stale data never looks valid
      end
    end
  end
endmodule
`default_nettype wire
